// ==== verilog/cbc_top.sv ====
// Purpose: Cell balance control: enable word, auto-off timer, fault clear.
// Assumes: Fault flags come from logic on clk; no synchroniser needed.
// Notes:   Squeeze select reroutes the enable word to the squeeze outputs.
`timescale 1ns/1ps

module cbc_top
    import cbc_pkg::*;
#(
    parameter int unsigned SEC_CYCLES_P = SEC_CYCLES
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         arst_n,
    // APB slave
    input  wire cbc_apb_req_s apb_req,
    output cbc_apb_rsp_s      apb_rsp,
    // Fault flags from the monitor
    input  wire logic [15:0]  fault_flags,
    input  wire logic         customer_checksum_error,
    // Channel drives
    output logic [15:0]       balance_out,
    output logic [15:0]       squeeze_out
);

    // ************************************************************
    // Declarations
    // ************************************************************
    logic [3:0]  cfg_dur_ff;
    logic        cfg_keep_ff;
    logic        tst_sqz_ff;
    logic [15:0] en_ff;
    logic [15:0] nxt_en;
    cbc_tmr_e    tmr_state_ff;
    cbc_tmr_e    nxt_tmr_state;
    logic [31:0] presc_ff;
    logic [11:0] secs_ff;
    logic        cks_ff;
    logic [15:0] balance_out_ff;
    logic [15:0] squeeze_out_ff;
    logic        pready_ff;
    logic        pslverr_ff;
    logic [31:0] prdata_ff;
    logic [31:0] nxt_prdata;
    logic        nxt_pslverr;

    logic        setup;
    logic        access;
    logic        wr_acc;
    logic [7:0]  idx;
    logic        addr_top_ok;
    logic        wr_cfg;
    logic        wr_en;
    logic        wr_tst;
    logic [15:0] wr_en_val;
    logic [15:0] wr_en_data;
    logic        wr_nonzero;
    logic        fault_lock;
    logic [11:0] limit;
    logic        timed;
    logic        sec_tick;
    logic        expire;
    logic [31:0] presc_last;
    logic        nxt_sqz;
    logic        tmr_clr;

    // ************************************************************
    // APB decode
    // ************************************************************
    // Setup latches the read answer; access completes with zero wait
    assign setup       = apb_req.psel & ~apb_req.penable;
    assign access      = apb_req.psel & apb_req.penable & pready_ff;
    assign wr_acc      = access & apb_req.pwrite;
    assign idx         = apb_req.paddr[9:2];
    assign addr_top_ok = (apb_req.paddr[11:10] == 2'b00);
    assign wr_cfg      = wr_acc & addr_top_ok & (idx == IDX_CFG);
    assign wr_en       = wr_acc & addr_top_ok & (idx == IDX_EN);
    assign wr_tst      = wr_acc & addr_top_ok & (idx == IDX_TST);

    // Byte lanes merge into the enable word; only strobed bytes count
    always_comb begin
        wr_en_val  = en_ff;
        wr_en_data = 16'h0000;
        for (int b = 0; b < 2; b++) begin
            if (apb_req.pstrb[b]) begin
                wr_en_val[b*8 +: 8]  = apb_req.pwdata[b*8 +: 8];
                wr_en_data[b*8 +: 8] = apb_req.pwdata[b*8 +: 8];
            end
        end
    end

    // Restart trigger looks only at the data actually written
    assign wr_nonzero = wr_en & (wr_en_data != 16'h0000);

    // ************************************************************
    // Fault handling
    // ************************************************************
    // Checksum error is not part of the flag vector, so never clears
    assign fault_lock = ~cfg_keep_ff & (|fault_flags);

    // ************************************************************
    // Duration decode and timebase
    // ************************************************************
    // Reserved codes behave as code zero: no automatic stop
    always_comb begin
        case (cfg_dur_ff)
            4'h1:    limit = SECS_1S;
            4'h2:    limit = SECS_1M;
            4'h3:    limit = SECS_2M;
            4'h4:    limit = SECS_5M;
            4'h5:    limit = SECS_10M;
            4'h6:    limit = SECS_15M;
            4'h7:    limit = SECS_20M;
            4'h8:    limit = SECS_30M;
            4'h9:    limit = SECS_60M;
            default: limit = 12'h000;
        endcase
    end

    // Timer qualifiers; reserved and zero codes never tick
    assign timed      = (limit != 12'h000);
    assign presc_last = SEC_CYCLES_P - 32'd1;
    assign sec_tick   = (tmr_state_ff == TMR_RUN) & timed
                      & (presc_ff == presc_last);
    assign expire     = (tmr_state_ff == TMR_RUN) & timed
                      & (secs_ff >= limit);

    // ************************************************************
    // Enable word next value
    // ************************************************************
    // Fault clear beats a write; a write beats expiry in the same cycle
    always_comb begin
        nxt_en = en_ff;
        if (fault_lock) begin
            nxt_en = 16'h0000;
        end else if (wr_en) begin
            nxt_en = wr_en_val;
        end else if (expire) begin
            nxt_en = 16'h0000;
        end
    end

    // Timer follows the enable word; restart on a non-zero write
    always_comb begin
        nxt_tmr_state = tmr_state_ff;
        case (tmr_state_ff)
            TMR_IDLE: begin
                if (wr_nonzero && nxt_en != 16'h0000) begin
                    nxt_tmr_state = TMR_RUN;
                end
            end
            TMR_RUN: begin
                if (nxt_en == 16'h0000) begin
                    nxt_tmr_state = TMR_IDLE;
                end
            end
            default: nxt_tmr_state = TMR_IDLE;
        endcase
    end

    // ************************************************************
    // Configuration registers
    // ************************************************************
    // Duration code; low three configuration bits are not stored at all
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_dur_ff <= CFG_DUR_RST;
        end else if (wr_cfg && apb_req.pstrb[0]) begin
            cfg_dur_ff <= apb_req.pwdata[CFG_DUR_LSB +: 4];
        end
    end

    // Fault choice; a change applies from the next cycle's fault check
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_keep_ff <= CFG_KEEP_RST;
        end else if (wr_cfg && apb_req.pstrb[0]) begin
            cfg_keep_ff <= apb_req.pwdata[CFG_KEEP_BIT];
        end
    end

    // Route change lands at the write edge, like an enable write
    assign nxt_sqz = (wr_tst && apb_req.pstrb[0])
                   ? apb_req.pwdata[TST_SQZ_BIT] : tst_sqz_ff;

    // Squeeze select in the test configuration word
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tst_sqz_ff <= TST_SQZ_RST;
        end else begin
            tst_sqz_ff <= nxt_sqz;
        end
    end

    // ************************************************************
    // Enable word and timer state
    // ************************************************************
    // Enable word; all priority sits in the next-value logic
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            en_ff <= EN_RST;
        end else begin
            en_ff <= nxt_en;
        end
    end

    // Timer state
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tmr_state_ff <= TMR_IDLE;
        end else begin
            tmr_state_ff <= nxt_tmr_state;
        end
    end

    // Own counters; only a non-zero enable write or a stop clears them, other traffic cannot
    assign tmr_clr = wr_nonzero | (nxt_tmr_state == TMR_IDLE);

    // Prescaler; frozen while the duration code is untimed
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            presc_ff <= 32'h0000_0000;
        end else if (tmr_clr || sec_tick) begin
            presc_ff <= 32'h0000_0000;
        end else if (tmr_state_ff == TMR_RUN && timed) begin
            presc_ff <= presc_ff + 32'h0000_0001;
        end
    end

    // Elapsed seconds; saturates so a long run never wraps under the limit
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            secs_ff <= 12'h000;
        end else if (tmr_clr) begin
            secs_ff <= 12'h000;
        end else if (sec_tick && secs_ff != 12'hFFF) begin
            secs_ff <= secs_ff + 12'h001;
        end
    end

    // Checksum error level, shown in status only
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cks_ff <= 1'b0;
        end else begin
            cks_ff <= customer_checksum_error;
        end
    end

    // ************************************************************
    // Channel drives
    // ************************************************************
    // Built from next values so outputs match the register read-back
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            balance_out_ff <= 16'h0000;
        end else begin
            balance_out_ff <= nxt_sqz ? 16'h0000 : nxt_en;
        end
    end

    // Squeeze legs take the same word while the select is set
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            squeeze_out_ff <= 16'h0000;
        end else begin
            squeeze_out_ff <= nxt_sqz ? nxt_en : 16'h0000;
        end
    end

    // Ports straight from the drive flops
    assign balance_out = balance_out_ff;
    assign squeeze_out = squeeze_out_ff;

    // ************************************************************
    // APB read mux and answer
    // ************************************************************
    // Unmapped words read zero and flag an error; writes there drop
    always_comb begin
        nxt_prdata  = 32'h0000_0000;
        nxt_pslverr = 1'b0;
        if (!addr_top_ok) begin
            nxt_pslverr = 1'b1;
        end else begin
            case (idx)
                IDX_CFG: begin
                    nxt_prdata[CFG_DUR_LSB +: 4] = cfg_dur_ff;
                    nxt_prdata[CFG_KEEP_BIT]     = cfg_keep_ff;
                end
                IDX_EN: begin
                    nxt_prdata[15:0] = en_ff;
                end
                IDX_TST: begin
                    nxt_prdata[TST_SQZ_BIT] = tst_sqz_ff;
                end
                IDX_STAT: begin
                    nxt_prdata[0] = (tmr_state_ff == TMR_RUN);
                    nxt_prdata[1] = fault_lock;
                    nxt_prdata[2] = cks_ff;
                    nxt_prdata[ST_SECS_LSB +: 12] = secs_ff;
                end
                default: nxt_pslverr = 1'b1;
            endcase
        end
    end

    // One wait-free access cycle after every setup
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff  <= setup;
            pslverr_ff <= setup & nxt_pslverr;
        end
    end

    // Read word frozen at setup; a write answers with zero
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            prdata_ff <= 32'h0000_0000;
        end else if (setup) begin
            prdata_ff <= apb_req.pwrite ? 32'h0000_0000 : nxt_prdata;
        end
    end

    // Answer fields straight from flops
    assign apb_rsp.pready  = pready_ff;
    assign apb_rsp.pslverr = pslverr_ff;
    assign apb_rsp.prdata  = prdata_ff;

endmodule

// ==== verilog/cbc_pkg.sv ====
// Purpose: Shared constants and types for cell balance control.
// Assumes: APB with 32-bit data; each register is one aligned word.
// Notes:   Register indices are kept as printed; byte address = index * 4.
package cbc_pkg;

    // ************************************************************
    // Clock and timebase
    // ************************************************************
    localparam int unsigned CLK_HZ       = 40_000_000;
    localparam int unsigned BAL_TICK_S   = 1;
    localparam int unsigned SEC_CYCLES   = BAL_TICK_S * CLK_HZ;

    // ************************************************************
    // Register indices and field positions
    // ************************************************************
    localparam logic [7:0]  IDX_CFG      = 8'h13;
    localparam logic [7:0]  IDX_EN       = 8'h14;
    localparam logic [7:0]  IDX_TST      = 8'h1E;
    localparam logic [7:0]  IDX_STAT     = 8'h3F;
    localparam int unsigned CFG_DUR_LSB  = 4;
    localparam int unsigned CFG_KEEP_BIT = 3;
    localparam int unsigned TST_SQZ_BIT  = 4;
    localparam int unsigned ST_SECS_LSB  = 16;
    localparam logic [3:0]  CFG_DUR_RST  = 4'h0;
    localparam logic        CFG_KEEP_RST = 1'b0;
    localparam logic        TST_SQZ_RST  = 1'b0;
    localparam logic [15:0] EN_RST       = 16'h0000;

    // ************************************************************
    // Balance duration limits, in seconds
    // ************************************************************
    localparam logic [11:0] SECS_1S      = 12'h001;
    localparam logic [11:0] SECS_1M      = 12'h03C;
    localparam logic [11:0] SECS_2M      = 12'h078;
    localparam logic [11:0] SECS_5M      = 12'h12C;
    localparam logic [11:0] SECS_10M     = 12'h258;
    localparam logic [11:0] SECS_15M     = 12'h384;
    localparam logic [11:0] SECS_20M     = 12'h4B0;
    localparam logic [11:0] SECS_30M     = 12'h708;
    localparam logic [11:0] SECS_60M     = 12'hE10;

    typedef enum logic [1:0] {
        TMR_IDLE = 2'b00,
        TMR_RUN  = 2'b01
    } cbc_tmr_e;

    // APB request and answer
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
        logic [3:0]  pstrb;
    } cbc_apb_req_s;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } cbc_apb_rsp_s;

endpackage

// ==== tb/cbc_fet_model.sv ====
// Purpose: Far side: one n-FET per cell channel and per squeeze leg.
// Assumes: Gate high turns the transistor on; no turn-on delay.
// Notes:   Drain state is shown so the bench can see what conducts.
`timescale 1ns/1ps
module cbc_fet_model (
    // Gates from the block
    input  wire logic [15:0] gate_bal,
    input  wire logic [15:0] gate_sqz,
    // Conducting channels, bit n is cell n+1
    output logic [15:0]      cell_drain,
    output logic [15:0]      sqz_drain
);
    // Each gate drives its own cell, no crossing of lanes
    assign cell_drain = gate_bal;
    assign sqz_drain  = gate_sqz;
endmodule

// ==== tb/cbc_top_props.sv ====
// Purpose: Checker on the ports of cbc_top.
// Assumes: Config state is shadowed from completed APB writes.
// Notes:   Bound to the top module after the checker.
`timescale 1ns/1ps
module cbc_top_props
    import cbc_pkg::*;
#(
    parameter int unsigned SEC_CYCLES_P = SEC_CYCLES
) (
    // Clock and reset
    input wire logic         clk,
    input wire logic         arst_n,
    // APB and faults
    input wire cbc_apb_req_s apb_req,
    input wire cbc_apb_rsp_s apb_rsp,
    input wire logic [15:0]  fault_flags,
    input wire logic         customer_checksum_error,
    // Channel drives
    input wire logic [15:0]  balance_out,
    input wire logic [15:0]  squeeze_out
);
    logic        acc;
    logic        wr;
    logic        lock;
    logic        keep_ff;
    logic        sqz_ff;
    logic [3:0]  dur_ff;
    logic [15:0] cnt_ff;
    logic [15:0] drv;
    logic [15:0] wd;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    // Completed transfers and fault lockout
    assign acc  = apb_req.psel && apb_req.penable && apb_rsp.pready;
    assign wr   = acc && apb_req.pwrite;
    assign lock = !keep_ff && (|fault_flags);
    assign drv  = balance_out | squeeze_out;
    assign wd   = apb_req.pwdata[15:0];
    // Config shadow, lane 0 only like the slave
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            keep_ff <= 1'b0;
            dur_ff  <= 4'h0;
            sqz_ff  <= 1'b0;
        end else if (wr && apb_req.pstrb[0]) begin
            if (apb_req.paddr == 12'h04C) begin
                keep_ff <= apb_req.pwdata[3];
                dur_ff  <= apb_req.pwdata[7:4];
            end
            if (apb_req.paddr == 12'h078) begin
                sqz_ff <= apb_req.pwdata[4];
            end
        end
    end
    // Cycles since last write; saturates so it never wraps
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_ff <= 16'h0000;
        end else if (wr) begin
            cnt_ff <= 16'h0000;
        end else if (cnt_ff != 16'hFFFF) begin
            cnt_ff <= cnt_ff + 16'h0001;
        end
    end
    property p_route;
        (sqz_ff ? balance_out : squeeze_out) == 16'h0000;
    endproperty
    a_route: assert property (p_route)
        else $error("wrong drive route");
    property p_hold;
        keep_ff && dur_ff == 4'h0 && !wr |=> $stable(drv);
    endproperty
    a_hold: assert property (p_hold) else $error("drive moved");
    property p_en_write;
        wr && apb_req.paddr == 12'h050 && apb_req.pstrb == 4'hF && !lock
            |=> drv == $past(wd);
    endproperty
    a_en_write: assert property (p_en_write)
        else $error("enable lost");
    property p_fault_clear;
        lock |=> drv == 16'h0000;
    endproperty
    a_fault_clear: assert property (p_fault_clear)
        else $error("no clear");
    property p_lock_write;
        lock && wr && apb_req.paddr == 12'h050 |=> (drv == 16'h0000) [*2];
    endproperty
    a_lock_write: assert property (p_lock_write)
        else $error("write taken");
    property p_cfg_rd;
        acc && !apb_req.pwrite && apb_req.paddr == 12'h04C
            |-> apb_rsp.prdata[2:0] == 3'h0 && apb_rsp.prdata[31:8] == 24'h0;
    endproperty
    a_cfg_rd: assert property (p_cfg_rd) else $error("config bits");
    property p_tst_rd;
        acc && !apb_req.pwrite && apb_req.paddr == 12'h078
            |-> apb_rsp.prdata == {27'h0, sqz_ff, 4'h0};
    endproperty
    a_tst_rd: assert property (p_tst_rd) else $error("test config");
    property p_expire;
        keep_ff && dur_ff == 4'h1 && cnt_ff == 16'(SEC_CYCLES_P + 3)
            |-> drv == 16'h0000;
    endproperty
    a_expire: assert property (p_expire) else $error("no expiry");
    // Main scenarios
    c_en_write: cover property (wr && apb_req.paddr == 12'h050);
    c_lock: cover property (lock);
    c_expire: cover property (keep_ff && dur_ff == 4'h1 && $fell(|drv));
endmodule
bind cbc_top cbc_top_props #(.SEC_CYCLES_P(SEC_CYCLES_P)) i_props (
    .clk(clk), .arst_n(arst_n), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .fault_flags(fault_flags),
    .customer_checksum_error(customer_checksum_error),
    .balance_out(balance_out), .squeeze_out(squeeze_out));

// ==== tb/tb_top.sv ====
// Purpose: Self-checking bench for cell balance control.
// Assumes: One second shortened to SEC cycles.
// Notes:   One idle cycle between APB transfers.
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
    fails++; $display("mismatch at %0t: got %h want %h", $time, g, e); \
    end end
module tb_top;
    import cbc_pkg::*;
    localparam int unsigned SEC = 8;
    localparam logic [11:0] A_CFG = 12'h04C;
    localparam logic [11:0] A_EN  = 12'h050;
    localparam logic [11:0] A_TST = 12'h078;
    logic         clk;
    logic         arst_n;
    cbc_apb_req_s req;
    cbc_apb_rsp_s rsp;
    logic [15:0]  flt;
    logic         cce;
    logic [15:0]  bal;
    logic [15:0]  sqz;
    logic [15:0]  drain;
    logic [15:0]  sdrain;
    logic [31:0]  rdata;
    logic         rerr;
    int           fails = 0;
    int           samples_checked = 0;
    int           cyc = 0;
    int unsigned  secs[9] = '{1, 60, 120, 300, 600, 900, 1200, 1800, 3600};
    logic [3:0]   free[3] = '{4'h0, 4'hA, 4'hF};
    cbc_top #(.SEC_CYCLES_P(SEC)) i_dut (
        .clk(clk), .arst_n(arst_n), .apb_req(req), .apb_rsp(rsp),
        .fault_flags(flt), .customer_checksum_error(cce),
        .balance_out(bal), .squeeze_out(sqz));
    cbc_fet_model i_fets (
        .gate_bal(bal), .gate_sqz(sqz), .cell_drain(drain),
        .sqz_drain(sdrain));
    // Clock, 25 ns period
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Verdict and end of run
    task automatic summarize;
        $display("checks %0d fails %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // One APB transfer; request held until pready is sampled
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d);
        int n;
        n = 0;
        req.psel    <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite  <= w;
        req.paddr   <= a;
        req.pwdata  <= d;
        req.pstrb   <= 4'hF;
        @(posedge clk);
        req.penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            fails++;
            $display("mismatch at %0t: no pready", $time);
            summarize();
        end
        rdata = rsp.prdata;
        rerr  = rsp.pslverr;
        req.psel    <= 1'b0;
        req.penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        `CHK(rdata, e)
    endtask
    // Hang guard, well above the timed sweep
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            fails++;
            $display("mismatch at %0t: timeout", $time);
            summarize();
        end
    end
    initial begin
        arst_n = 1'b0;
        req    = '0;
        flt    = 16'h0000;
        cce    = 1'b0;
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        rd(A_CFG, 32'h0);
        rd(A_EN, 32'h0);
        xfer(1'b0, 12'h004, 32'h0);
        `CHK({rerr, rdata}, {1'b1, 32'h0})
        xfer(1'b1, A_CFG, 32'hFF);
        rd(A_CFG, 32'hF8);
        xfer(1'b1, A_CFG, 32'h08);
        xfer(1'b1, A_EN, 32'h8001);
        `CHK({bal, sqz, drain}, {16'h8001, 16'h0, 16'h8001})
        xfer(1'b1, A_TST, 32'h10);
        rd(A_TST, 32'h10);
        `CHK({bal, sqz, sdrain}, {16'h0, 16'h8001, 16'h8001})
        xfer(1'b1, A_TST, 32'h0);
        flt <= 16'h0001;
        xfer(1'b1, A_EN, 32'h0003);
        `CHK(bal, 16'h0003)
        flt <= 16'h0000;
        cce <= 1'b1;
        xfer(1'b1, A_CFG, 32'h0);
        repeat (3) @(posedge clk);
        `CHK(bal, 16'h0003)
        flt <= 16'h8000;
        repeat (2) @(posedge clk);
        `CHK(bal, 16'h0)
        xfer(1'b1, A_EN, 32'h00FF);
        rd(A_EN, 32'h0);
        rd(12'h0FC, 32'h6);
        flt <= 16'h0000;
        cce <= 1'b0;
        xfer(1'b1, A_EN, 32'hFFFF);
        `CHK(bal, 16'hFFFF)
        xfer(1'b1, A_EN, 32'h0);
        `CHK(bal, 16'h0)
        // Restart just before the first second runs out
        xfer(1'b1, A_CFG, 32'h18);
        xfer(1'b1, A_EN, 32'h0F0F);
        repeat (SEC - 4) @(posedge clk);
        xfer(1'b1, A_EN, 32'h00F0);
        repeat (SEC - 3) @(posedge clk);
        `CHK(bal, 16'h00F0)
        repeat (6) @(posedge clk);
        rd(A_EN, 32'h0);
        foreach (free[i]) begin
            xfer(1'b1, A_CFG, {24'h0, free[i], 4'h8});
            xfer(1'b1, A_EN, 32'h1);
            repeat (3 * SEC) @(posedge clk);
            `CHK(bal, 16'h0001)
        end
        for (int i = 0; i < 9; i++) begin
            xfer(1'b1, A_CFG, {24'h0, 4'(i + 1), 4'h8});
            xfer(1'b1, A_EN, 32'h1);
            repeat (secs[i] * SEC - 3) @(posedge clk);
            `CHK(bal, 16'h0001)
            repeat (6) @(posedge clk);
            `CHK(bal, 16'h0)
        end
        summarize();
    end
endmodule
